// File: rtl/dps_pkg.sv
// shared constants and types of the time-code pulse simulator
package dps_pkg;

   // ************************************************************
   // timing
   // ************************************************************
   localparam int unsigned CLK_PERIOD_NS = 20;          // system clock period
   localparam int unsigned MS_PERIOD_NS  = 1000000;     // one millisecond
   localparam int unsigned MS_CYCLES     = MS_PERIOD_NS / CLK_PERIOD_NS;
   localparam logic [9:0]  HALF_2HZ_MS   = 10'h0FA;     // 250 ms half period
   localparam logic [9:0]  MS_SAT        = 10'h3FF;     // ms counter ceiling

   // ************************************************************
   // pulse lengths in ms
   // ************************************************************
   localparam logic [7:0] SHORT_MIN_MS = 8'h46;         // 70 ms
   localparam logic [7:0] SHORT_MAX_MS = 8'h8C;         // 140 ms
   localparam logic [7:0] SHORT_DEF_MS = 8'h64;         // 100 ms
   localparam logic [7:0] LONG_MIN_MS  = 8'h8C;         // 140 ms
   localparam logic [7:0] LONG_MAX_MS  = 8'hF0;         // 240 ms
   localparam logic [7:0] LONG_DEF_MS  = 8'hC8;         // 200 ms

   // ************************************************************
   // holdover and frame
   // ************************************************************
   localparam logic [10:0] HOLD_MAX_MIN = 11'h5A0;      // 24 hours
   localparam logic [10:0] HOLD_DEF_MIN = 11'h000;
   localparam logic [5:0]  LAST_SEC     = 6'h3B;        // second 59, no pulse
   localparam int unsigned TIME_W       = 35;           // bcd time word width
   localparam int unsigned FRAME_W      = 59;           // bits 0..58

   // ************************************************************
   // frame bit positions
   // ************************************************************
   localparam int unsigned BIT_ANN  = 16;
   localparam int unsigned BIT_Z1   = 17;
   localparam int unsigned BIT_Z2   = 18;
   localparam int unsigned BIT_ST   = 20;
   localparam int unsigned BIT_MIN  = 21;
   localparam int unsigned BIT_P1   = 28;
   localparam int unsigned BIT_HR   = 29;
   localparam int unsigned BIT_P2   = 35;
   localparam int unsigned BIT_DATE = 36;
   localparam int unsigned BIT_P3   = 58;

   // ************************************************************
   // modes
   // ************************************************************
   typedef enum logic [1:0]
   {
      BASE_LOCAL = 2'b00,
      BASE_STD   = 2'b01,
      BASE_UTC   = 2'b10
   } dps_base_e;

   typedef enum logic [1:0]
   {
      ZONE_LOCAL  = 2'b00,
      ZONE_WINTER = 2'b01,
      ZONE_SUMMER = 2'b10,
      ZONE_NONE   = 2'b11
   } dps_zone_e;

   typedef enum logic [1:0]
   {
      FLT_2HZ_INVALID  = 2'b00,
      FLT_2HZ_NOSYNC   = 2'b01,
      FLT_OFF_INVALID  = 2'b10,
      FLT_OFF_NOSYNC   = 2'b11
   } dps_fault_e;

endpackage

// File: rtl/dps_pulse_sim.sv
// time-code pulse generator with fault handling and minute-aligned settings
//
// Behaviour
// - local base jumps an hour at changeover
// - standard base encodes winter time all year
// - settings take effect only at minute boundary
// - local zone status follows current zone
// - always-standard encodes winter, no announcement
// - always-summer encodes summer, no announcement
// - no-zone mode clears zone bits, no announcement
// - zone override leaves time and date alone
// - base change reloads matching zone default
// - low-active polarity inverts the output
// - 2 Hz instead of code when time invalid
// - 2 Hz after holdover expiry without reception
// - output inactive while time invalid
// - output stops after holdover expiry
// - holdover 0 minutes to 24 hours
// - holdover taken only in not-sync modes
// - short pulse 70 to 140 ms, default 100
// - long pulse 140 to 240 ms, default 200
module dps_pulse_sim
   import dps_pkg::*;
#(
   parameter int unsigned P_MS_CYCLES = MS_CYCLES      // clock cycles per millisecond
)
(
   // clock and reset
   input  wire logic              i_clk,
   input  wire logic              i_reset_n,
   // time references
   input  wire logic              i_sec_tick,          // start of each second
   input  wire logic              i_min_tick,          // start of second 0
   input  wire logic [TIME_W-1:0] i_local_time,        // bcd time word, local base
   input  wire logic [TIME_W-1:0] i_std_time,          // bcd time word, standard base
   input  wire logic [TIME_W-1:0] i_utc_time,          // bcd time word, utc base
   // clock status
   input  wire logic              i_summer_time_flag,  // summer time in force
   input  wire logic              i_zone_announce,     // zone change imminent
   input  wire logic              i_time_valid,        // clock holds a valid time
   input  wire logic              i_sync,              // satellite reception present
   // settings
   input  wire logic [1:0]        i_time_base,
   input  wire logic [1:0]        i_zone_mode,
   input  wire logic              i_zone_wr,           // load i_zone_mode
   input  wire logic              i_low_active,
   input  wire logic [1:0]        i_fault_mode,
   input  wire logic [10:0]       i_holdover_min,
   input  wire logic [7:0]        i_short_ms,
   input  wire logic [7:0]        i_long_ms,
   // outputs
   output logic                   o_dcf_pulse,
   output logic [5:0]             o_second,
   output logic                   o_fault_active,
   output logic                   o_holdover_expired
);

   // ************************************************************
   // helpers
   // ************************************************************

   // clamp a value into [lo, hi]; out-of-range lengths are clamped rather than
   // refused, so the line never carries a pulse that a receiver cannot classify
   function automatic logic [7:0] clamp8(input logic [7:0] v, input logic [7:0] lo, input logic [7:0] hi);
      logic [7:0] r;
      r = v;
      if (v < lo)
      begin
         r = lo;
      end
      else if (v > hi)
      begin
         r = hi;
      end
      return r;
   endfunction

   // not-sync fault modes use the holdover timer
   function automatic logic is_nosync(input logic [1:0] m);
      return (m == FLT_2HZ_NOSYNC) || (m == FLT_OFF_NOSYNC);
   endfunction

   // ************************************************************
   // active settings, changed only at the minute boundary
   // ************************************************************
   // base and zone need no copy of their own: the frame register, loaded at
   // the minute tick, is what holds them steady for the whole minute
   dps_zone_e   zone_reg;                             // zone selection (pending)
   logic [1:0]  base_seen_reg;                        // last base seen on the port
   logic        low_reg;                              // polarity in use
   dps_fault_e  fault_reg;                            // fault mode in use
   logic [10:0] hold_reg;                             // holdover minutes in use
   logic [7:0]  short_reg;                            // short pulse ms in use
   logic [7:0]  long_reg;                             // long pulse ms in use

   wire logic        base_changed = (i_time_base != base_seen_reg);
   wire logic [1:0]  base_safe    = (i_time_base == 2'b11) ? BASE_LOCAL : i_time_base;
   wire logic [10:0] hold_clamped = (i_holdover_min > HOLD_MAX_MIN) ? HOLD_MAX_MIN : i_holdover_min;
   wire logic [7:0]  short_clamp  = clamp8(i_short_ms, SHORT_MIN_MS, SHORT_MAX_MS);
   wire logic [7:0]  long_clamp   = clamp8(i_long_ms, LONG_MIN_MS, LONG_MAX_MS);

   // default zone that belongs to a base
   logic [1:0] zone_default;
   assign zone_default = (base_safe == BASE_LOCAL) ? ZONE_LOCAL :
                         (base_safe == BASE_STD)   ? ZONE_WINTER : ZONE_NONE;

   // zone selection register: a base change overrides a same-cycle write,
   // so the pending zone never mismatches a freshly chosen base
   always_ff @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         zone_reg      <= ZONE_LOCAL;
         base_seen_reg <= BASE_LOCAL;
      end
      else
      begin
         base_seen_reg <= i_time_base;
         if (base_changed)
         begin
            zone_reg <= dps_zone_e'(zone_default);
         end
         else if (i_zone_wr)
         begin
            zone_reg <= dps_zone_e'(i_zone_mode);
         end
      end
   end

   // all pulse-output settings are sampled together at the minute tick
   // so a frame already on the line never mixes old and new lengths
   always_ff @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         low_reg      <= 1'b0;
         fault_reg    <= FLT_2HZ_INVALID;
         hold_reg     <= HOLD_DEF_MIN;
         short_reg    <= SHORT_DEF_MS;
         long_reg     <= LONG_DEF_MS;
      end
      else if (i_min_tick)
      begin
         low_reg      <= i_low_active;
         fault_reg    <= dps_fault_e'(i_fault_mode);
         if (is_nosync(i_fault_mode))
         begin
            hold_reg <= hold_clamped;
         end
         short_reg    <= short_clamp;
         long_reg     <= long_clamp;
      end
   end

   // ************************************************************
   // frame assembly
   // ************************************************************

   // the three words are supplied ready-made; no offset arithmetic is done here
   // the base picks the time word; the zone mode never touches it
   logic [TIME_W-1:0] time_sel;
   assign time_sel = (base_safe == BASE_STD) ? i_std_time :
                     (base_safe == BASE_UTC) ? i_utc_time :
                     i_local_time;

   // zone and announcement bits use the settings about to become active
   logic       z1_bit;
   logic       z2_bit;
   logic       ann_bit;
   assign z1_bit  = (zone_reg == ZONE_LOCAL)  ? i_summer_time_flag :
                    (zone_reg == ZONE_SUMMER);
   assign z2_bit  = (zone_reg == ZONE_LOCAL)  ? !i_summer_time_flag :
                    (zone_reg == ZONE_WINTER);
   assign ann_bit = (zone_reg == ZONE_LOCAL) && i_zone_announce;

   // time word: minute[6:0] hour[12:7] date[34:13]
   logic [FRAME_W-1:0] frame_next;
   always_comb
   begin
      frame_next                 = '0;
      frame_next[BIT_ANN]        = ann_bit;
      frame_next[BIT_Z1]         = z1_bit;
      frame_next[BIT_Z2]         = z2_bit;
      frame_next[BIT_ST]         = 1'b1;
      frame_next[BIT_MIN +: 7]   = time_sel[6:0];
      frame_next[BIT_P1]         = ^time_sel[6:0];
      frame_next[BIT_HR +: 6]    = time_sel[12:7];
      frame_next[BIT_P2]         = ^time_sel[12:7];
      frame_next[BIT_DATE +: 22] = time_sel[34:13];
      frame_next[BIT_P3]         = ^time_sel[34:13];
   end

   logic [FRAME_W-1:0] frame_reg;                     // frame being sent

   // frame is latched at the minute tick so it never changes mid-minute
   always_ff @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         frame_reg <= '0;
      end
      else if (i_min_tick)
      begin
         frame_reg <= frame_next;
      end
   end

   // ************************************************************
   // second and millisecond timing
   // ************************************************************
   // divider width: a one-clock millisecond still needs a one-bit counter,
   // since a zero-width divider would not elaborate
   localparam int unsigned DIV_W = (P_MS_CYCLES > 1) ? $clog2(P_MS_CYCLES) : 1;

   logic [DIV_W-1:0]               div_reg;           // ms divider
   logic [9:0]                     ms_reg;            // ms into the second
   logic [5:0]                     sec_reg;           // second of the minute

   wire logic ms_tick = (div_reg == DIV_W'(P_MS_CYCLES - 1));

   // divider restarts on each second so ms stays aligned to the second edge
   // the ms count saturates so a missing second tick leaves the line quiet
   always_ff @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         div_reg <= '0;
         ms_reg  <= MS_SAT;
      end
      else if (i_sec_tick)
      begin
         div_reg <= '0;
         ms_reg  <= '0;
      end
      else if (ms_tick)
      begin
         div_reg <= '0;
         if (ms_reg != MS_SAT)
         begin
            ms_reg <= ms_reg + 10'h001;
         end
      end
      else
      begin
         div_reg <= div_reg + 1'b1;
      end
   end

   // second counter; the minute tick forces second 0
   // the minute tick must come with a second tick: a lone minute tick would
   // restart the index but leave the ms count of the old second running on
   always_ff @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         sec_reg <= LAST_SEC;
      end
      else if (i_min_tick)
      begin
         sec_reg <= 6'h00;
      end
      else if (i_sec_tick && (sec_reg != LAST_SEC))
      begin
         sec_reg <= sec_reg + 6'h01;
      end
   end

   // ************************************************************
   // holdover after loss of reception
   // ************************************************************
   logic [10:0] sync_loss_holdover_timer;             // minutes without reception

   // counts whole minutes while reception is absent; saturates at HOLD_MAX_MIN
   // a drop just before a tick counts as a whole minute, so the holdover is
   // only as fine as one minute
   always_ff @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         sync_loss_holdover_timer <= '0;
      end
      else if (i_sync)
      begin
         sync_loss_holdover_timer <= '0;
      end
      else if (i_min_tick && (sync_loss_holdover_timer != HOLD_MAX_MIN))
      begin
         sync_loss_holdover_timer <= sync_loss_holdover_timer + 11'h001;
      end
   end

   // with zero holdover the fault applies as soon as reception drops
   wire logic hold_expired = !i_sync && (sync_loss_holdover_timer >= hold_reg);

   // ************************************************************
   // output selection
   // ************************************************************
   // a fault takes the line at once, mid-frame if need be: a receiver should
   // see the loss of reception as soon as the holdover runs out
   wire logic [1:0] flt      = fault_reg;
   wire logic       fault_on = is_nosync(flt) ? hold_expired : !i_time_valid;
   wire logic       use_2hz  = (flt == FLT_2HZ_INVALID) || (flt == FLT_2HZ_NOSYNC);

   // square wave: high 0..249, low 250..499, high 500..749, low 750..999
   wire logic [9:0] ms_half  = (ms_reg >= (HALF_2HZ_MS << 1)) ? ms_reg - (HALF_2HZ_MS << 1) : ms_reg;
   wire logic       sq_2hz   = (ms_half < HALF_2HZ_MS);

   // code pulse: bit value picks the length, last second stays quiet
   // bit 58 is the last one sent; second 59 reads as zero and is gated anyway
   wire logic       bit_val  = (sec_reg < 6'(FRAME_W)) ? frame_reg[sec_reg] : 1'b0;
   wire logic [7:0] len_ms   = bit_val ? long_reg : short_reg;
   wire logic       code_on  = (sec_reg != LAST_SEC) && (ms_reg < {2'b00, len_ms});

   logic nominal;
   assign nominal = !fault_on ? code_on :
                    use_2hz   ? sq_2hz  :
                    1'b0;

   // registered outputs, so the line carries no decode glitches
   always_ff @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         o_dcf_pulse        <= 1'b0;
         o_second           <= LAST_SEC;
         o_fault_active     <= 1'b0;
         o_holdover_expired <= 1'b0;
      end
      else
      begin
         o_dcf_pulse        <= nominal ^ low_reg;
         o_second           <= sec_reg;
         o_fault_active     <= fault_on;
         o_holdover_expired <= hold_expired;
      end
   end

endmodule

// File: test/dps_rx_model.sv
// receiver model: measures the width of every active pulse on the line
module dps_rx_model
(
   // clock and reset
   input  wire logic i_clk,
   input  wire logic i_reset_n,
   // pulse line and the sense used to decode it
   input  wire logic i_line,
   input  wire logic i_low_active
);
   timeunit 1ns;
   timeprecision 1ns;
   int widths[$];   // completed pulse widths in clocks
   int run = 0;     // clocks of the pulse now in progress
   // a pulse ends when the line returns to idle; the bench clears the queue per frame
   always @(posedge i_clk)
   begin
      if (!i_reset_n)
         run = 0;
      else if (i_line ^ i_low_active)
         run++;
      else if (run > 0)
      begin
         widths.push_back(run);
         run = 0;
      end
   end
endmodule

// File: test/dps_pulse_sim_chk.sv
// concurrent checks on the ports of the pulse simulator
module dps_pulse_sim_chk
(
   // clock, reset and time references
   input  wire logic       i_clk,
   input  wire logic       i_reset_n,
   input  wire logic       i_sec_tick,
   input  wire logic       i_min_tick,
   input  wire logic       i_sync,
   // outputs under watch
   input  wire logic       o_dcf_pulse,
   input  wire logic [5:0] o_second,
   input  wire logic       o_fault_active,
   input  wire logic       o_holdover_expired
);
   timeunit 1ns;
   timeprecision 1ns;
   // ************************************************************
   // assertions, all in the one clock domain
   // ************************************************************
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_reset_n);
   AST_MIN_RESTART:
   // o_second and the line trail a tick by two edges: internal index, then register
   assert property (i_min_tick |-> ##2 o_second == 6'h00) else $error("second not zero after minute tick");
   AST_SEC_STEP:
   assert property (i_sec_tick && !i_min_tick ##1 o_second < 6'h3B |=> o_second == $past(o_second) + 6'h01)
      else $error("second index did not advance");
   AST_SEC_HOLD:
   assert property (!i_sec_tick && !i_min_tick |-> ##2 $stable(o_second))
      else $error("second index moved without tick");
   AST_SEC_RANGE:
   assert property (o_second <= 6'h3B) else $error("second index above 59");
   // second 59 carries no pulse, so the line stays where it is
   AST_GAP_QUIET:
   assert property (o_second == 6'h3B && $past(o_second) == 6'h3B && !o_fault_active && !$past(o_fault_active)
      |-> $stable(o_dcf_pulse)) else $error("line moved in second 59");
   // min tick excluded: a polarity swap there can hide the edge
   AST_PULSE_START:
   assert property (i_sec_tick && !i_min_tick && !o_fault_active && o_second < 6'h3A
      |-> ##2 o_fault_active || $changed(o_dcf_pulse)) else $error("no pulse at second start");
   AST_SYNC_CLEARS:
   assert property (i_sync [*2] |=> !o_holdover_expired) else $error("holdover expired with reception");
   AST_EXPIRE_CAUSE:
   assert property (o_holdover_expired |-> !$past(i_sync)) else $error("holdover expired while synced");
   COV_MINUTE: cover property (i_min_tick ##1 o_second == 6'h00);
   COV_FAULT: cover property ($rose(o_fault_active));
   COV_EXPIRE: cover property ($rose(o_holdover_expired));
endmodule

bind dps_pulse_sim dps_pulse_sim_chk chk (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_sec_tick(i_sec_tick),
   .i_min_tick(i_min_tick), .i_sync(i_sync), .o_dcf_pulse(o_dcf_pulse), .o_second(o_second),
   .o_fault_active(o_fault_active), .o_holdover_expired(o_holdover_expired));

// File: test/tb.sv
// self-checking bench of the time-code pulse simulator
module tb import dps_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int P = 1;                 // one clock per ms keeps a minute short
   logic clk = 0, rst_n = 0, sec = 0, mnt = 0, summer = 0, ann = 0, valid = 1, sync = 1, zwr = 0, low = 0;
   logic [34:0] tl = '0, ts = '0, tu = '0; // time words of the three bases
   logic [1:0]  base = 2'h0, zm = 2'h0, fm = 2'h0;
   logic [10:0] hold = 11'h000;
   logic [7:0]  sh = 8'h46, lg = 8'hF0;  // boundary lengths for the first frame
   logic [1:0]  p_zone = ZONE_LOCAL;     // model of the pending zone selection
   logic        exp_low = 1'b0;          // polarity the receiver decodes with
   wire logic   pulse, fault, hexp;
   wire logic [5:0] sec_o;
   int seed = 32'h7ce427e4;
   int miscompares = 0, samples_checked = 0;
   // ************************************************************
   // clock, design and receiver
   // ************************************************************
   always #10 clk = ~clk;
   dps_pulse_sim #(.P_MS_CYCLES(P)) dut (.i_clk(clk), .i_reset_n(rst_n), .i_sec_tick(sec), .i_min_tick(mnt),
      .i_local_time(tl), .i_std_time(ts), .i_utc_time(tu), .i_summer_time_flag(summer), .i_zone_announce(ann),
      .i_time_valid(valid), .i_sync(sync), .i_time_base(base), .i_zone_mode(zm), .i_zone_wr(zwr),
      .i_low_active(low), .i_fault_mode(fm), .i_holdover_min(hold), .i_short_ms(sh), .i_long_ms(lg),
      .o_dcf_pulse(pulse), .o_second(sec_o), .o_fault_active(fault), .o_holdover_expired(hexp));
   dps_rx_model rx (.i_clk(clk), .i_reset_n(rst_n), .i_line(pulse), .i_low_active(exp_low));
   // ************************************************************
   // model, compares and drivers
   // ************************************************************
   // expected frame bits, built from the inputs sampled at the minute tick
   function automatic logic [58:0] mk_frame(input logic [34:0] t, input logic [1:0] z, input logic s, input logic an);
      logic [58:0] f;
      f = '0;
      f[16] = (z == ZONE_LOCAL) && an;
      f[17] = (z == ZONE_SUMMER) || (z == ZONE_LOCAL && s);
      f[18] = (z == ZONE_WINTER) || (z == ZONE_LOCAL && !s);
      f[20] = 1'b1;
      f[27:21] = t[6:0];
      f[28] = ^t[6:0];
      f[34:29] = t[12:7];
      f[35] = ^t[12:7];
      f[57:36] = t[34:13];
      f[58] = ^t[34:13];
      return f;
   endfunction
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         miscompares++;
         $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
      end
   endtask
   // widths allow two clocks for the registered edges and the polarity hand-over
   task automatic chk_w(input int got, input int exp);
      samples_checked++;
      if (got < exp - 2 || got > exp + 2)
      begin
         miscompares++;
         $display("MISMATCH t=%0t width got=%0h exp=%0h", $time, got, exp);
      end
   endtask
   task automatic tick(input logic m);
      @(posedge clk);
      sec <= 1'b1;
      mnt <= m;
      @(posedge clk);
      sec <= 1'b0;
      mnt <= 1'b0;
   endtask
   // mid-frame changes: must wait for the next minute
   task automatic mix(input int k);
      int r;
      r = $random(seed);
      @(posedge clk);
      sh <= 8'(70 + $unsigned($random(seed)) % 71);
      lg <= 8'(140 + $unsigned($random(seed)) % 101);
      low <= r[0];
      summer <= r[1];
      ann <= r[2];
      tl <= 35'({$random(seed), $random(seed)});
      ts <= 35'({$random(seed), $random(seed)});
      tu <= 35'({$random(seed), $random(seed)});
      if (k % 2 == 1)
      begin
         base <= 2'((k / 2 + 1) % 3);
         p_zone = ((k / 2 + 1) % 3 == 1) ? ZONE_WINTER : ((k / 2 + 1) % 3 == 2) ? ZONE_NONE : ZONE_LOCAL;
      end
      else
      begin
         zm <= 2'(k / 2);
         zwr <= 1'b1;
         p_zone = 2'(k / 2);
         @(posedge clk);
         zwr <= 1'b0;
      end
   endtask
   // one frame of n seconds of 260 clocks, bits decoded by pulse width
   task automatic run_frame(input int n, input int k);
      logic [58:0] f;
      logic [7:0]  s0, l0;
      f = mk_frame((base == BASE_STD) ? ts : (base == BASE_UTC) ? tu : tl, p_zone, summer, ann);
      s0 = sh;
      l0 = lg;
      rx.widths.delete();
      tick(1'b1);
      exp_low <= low;
      for (int s = 1; s <= n; s++)
      begin
         repeat (258) @(posedge clk);
         if (s == 2)
            mix(k);
         if (s < n)
            tick(1'b0);
      end
      chk(64'(rx.widths.size()), 64'((n == 60) ? 59 : n));
      for (int i = 0; i < rx.widths.size() && i < 59; i++)
         chk_w(rx.widths[i], (f[i] ? l0 : s0) * P);
      $display("frame test %0d done", k);
   endtask
   // one 1000 ms second after a minute tick in fault mode m
   task automatic fault_sec(input logic [1:0] m, input int n, input logic f_exp);
      fm <= m;
      rx.widths.delete();
      tick(1'b1);
      exp_low <= low;
      repeat (998) @(posedge clk);
      chk(64'(fault), 64'(f_exp));
      chk(64'(rx.widths.size()), 64'(n));
      for (int i = 0; f_exp && i < rx.widths.size(); i++)
         chk_w(rx.widths[i], 250 * P);
      $display("fault test mode %0d done", m);
   endtask
   task automatic end_sim();
      $display("checks %0d, mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // ************************************************************
   // test sequence and watchdog
   // ************************************************************
   initial
   begin
      repeat (15) @(posedge clk);
      chk(64'({pulse, fault, hexp, sec_o}), 64'({3'b000, LAST_SEC}));
      @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      for (int k = 0; k < 8; k++)
         run_frame((k % 2 == 0 && k < 6) ? 60 : 20, k);   // full frames on local, standard and utc bases
      valid <= 1'b0;
      fault_sec(2'b00, 2, 1'b1);
      fault_sec(2'b10, 0, 1'b1);
      chk(64'(pulse), 64'(exp_low));
      valid <= 1'b1;
      sync <= 1'b0;
      hold <= 11'h002;
      fault_sec(2'b01, 1, 1'b0);
      chk(64'(hexp), 64'h0);
      fault_sec(2'b01, 2, 1'b1);
      chk(64'(hexp), 64'h1);
      sync <= 1'b1;
      repeat (2) @(posedge clk);
      sync <= 1'b0;
      hold <= 11'h000;
      fault_sec(2'b10, 1, 1'b0);
      chk(64'(hexp), 64'h0);
      fault_sec(2'b11, 0, 1'b1);
      chk(64'(hexp), 64'h1);
      end_sim();
   end
   // the run needs about 79000 clocks; a hang is cut off well after that
   initial
   begin
      repeat (100000) @(posedge clk);
      miscompares++;
      end_sim();
   end
endmodule
